// ### rtl/pors_consts.vh
// constants for the power-on reset sequencer
// assumes a 100 MHz clock; the hold count is also a top-level parameter
`ifndef PORS_CONSTS_VH
`define PORS_CONSTS_VH
`define PORS_CLK_MHZ 100
`define PORS_HOLD_MS 100
`define PORS_HOLD_CYCLES (`PORS_HOLD_MS * 1000 * `PORS_CLK_MHZ)
`define PORS_CNT_W 24
`define PORS_PERIPH_W 8
`define PORS_ST_OFF 2'h0
`define PORS_ST_HOLD 2'h1
`define PORS_ST_RUN 2'h2
`endif

// ### rtl/pors_sequencer.v
// power-on reset and startup sequencer
// assumes power_on_sense and supply_fail_warning_n are synchronous to clk
`include "pors_consts.vh"
module pors_sequencer #(
  parameter HOLD_CYCLES = `PORS_HOLD_CYCLES
) (
  input wire clk, // 100 MHz clock
  input wire reset_n, // asynchronous reset, active low
  input wire power_on_sense, // supervisor power-on sense
  input wire supply_fail_warning_n, // early power-fail warning, active low
  input wire sys_reset_req, // watchdog or other system reset pulse
  input wire [`PORS_PERIPH_W-1:0] periph_release, // processor clock/reset release
  input wire low_power_req, // software low-power mode request
  output reg master_pll_rst_n, // master pll reset, active low
  output reg cpu_rst_n, // processor resets, active low
  output reg cpu_clk_en, // processor clocks at full rate
  output reg [`PORS_PERIPH_W-1:0] periph_clk_en, // other clock enables
  output reg [`PORS_PERIPH_W-1:0] periph_rst_n, // other resets, active low
  output reg low_power_mode, // low-power mode active
  output reg mirror_park // park request to micromirror array
);
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [`PORS_CNT_W-1:0] cnt_reg;
  reg [`PORS_CNT_W-1:0] cnt_next;
  reg sense_d_reg;
  wire sense_rise;
  wire [`PORS_CNT_W-1:0] hold_last;
  wire run_next;
  wire cpu_go;
  wire periph_open;
  wire park_go;

  // last count of the hold, cut to the counter width on purpose
  localparam [31:0] HOLD_LAST_FULL = HOLD_CYCLES - 1;

  // true when the given state is the running state
  function is_run;
    input [1:0] st;
    begin
      is_run = (st == `PORS_ST_RUN);
    end
  endfunction

  // true when the given state is the full-reset state
  function is_off;
    input [1:0] st;
    begin
      is_off = (st == `PORS_ST_OFF);
    end
  endfunction

  assign hold_last = HOLD_LAST_FULL[`PORS_CNT_W-1:0];
  assign sense_rise = power_on_sense & ~sense_d_reg;
  assign run_next = is_run(state_next);
  // a system reset pulls the processor back while it stands
  assign cpu_go = run_next & ~sys_reset_req;
  // peripheral requests are ignored in the first run cycle
  assign periph_open = cpu_go & is_run(state_reg);
  assign park_go = run_next & ~supply_fail_warning_n;

  always @*
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      `PORS_ST_OFF:
      begin
        cnt_next = {`PORS_CNT_W{1'b0}};
        if (sense_rise)
        begin
          state_next = `PORS_ST_HOLD;
        end
      end
      `PORS_ST_HOLD:
      begin
        if (cnt_reg == hold_last)
        begin
          state_next = `PORS_ST_RUN;
        end
        else
        begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      `PORS_ST_RUN:
      begin
        if (sys_reset_req)
        begin
          state_next = `PORS_ST_RUN;
        end
      end
      default:
      begin
        state_next = `PORS_ST_OFF;
      end
    endcase
    if (!power_on_sense)
    begin
      state_next = `PORS_ST_OFF;
    end
  end

  // state, hold counter and the sense edge history
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= `PORS_ST_OFF;
      cnt_reg <= {`PORS_CNT_W{1'b0}};
      sense_d_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      sense_d_reg <= power_on_sense;
    end
  end

  // outputs follow the next state so they change together with it
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      master_pll_rst_n <= 1'b0;
    end
    else
    begin
      master_pll_rst_n <= ~is_off(state_next);
    end
  end

  // processor resets released once the hold has run out
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cpu_rst_n <= 1'b0;
    end
    else
    begin
      cpu_rst_n <= cpu_go;
    end
  end

  // processor clocks at full rate together with their reset release
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cpu_clk_en <= 1'b0;
    end
    else
    begin
      cpu_clk_en <= cpu_go;
    end
  end

  // other clocks stay off until the processor asks for them
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      periph_clk_en <= {`PORS_PERIPH_W{1'b0}};
    end
    else if (periph_open)
    begin
      periph_clk_en <= periph_release;
    end
    else
    begin
      periph_clk_en <= {`PORS_PERIPH_W{1'b0}};
    end
  end

  // other resets stay asserted until the processor releases them
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      periph_rst_n <= {`PORS_PERIPH_W{1'b0}};
    end
    else if (periph_open)
    begin
      periph_rst_n <= periph_release;
    end
    else
    begin
      periph_rst_n <= {`PORS_PERIPH_W{1'b0}};
    end
  end

  // low-power mode only on software request, and only while running
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      low_power_mode <= 1'b0;
    end
    else if (periph_open)
    begin
      low_power_mode <= low_power_req;
    end
    else
    begin
      low_power_mode <= 1'b0;
    end
  end

  // park the mirrors on the power-fail warning, only while running; never while sense is low
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mirror_park <= 1'b0;
    end
    else
    begin
      mirror_park <= park_go;
    end
  end
endmodule

// ### test/pors_seq_monitor.sv
// checker on pors_sequencer ports; one clock, reset async active low
module pors_seq_monitor #(parameter int HOLD_CYCLES = 20) (input wire clk, reset_n,
  power_on_sense, supply_fail_warning_n, sys_reset_req, master_pll_rst_n, cpu_rst_n, // bits
  cpu_clk_en, mirror_park, input wire [7:0] periph_release, periph_clk_en, periph_rst_n);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence s_hold; !cpu_rst_n ##HOLD_CYCLES cpu_rst_n; endsequence
  sense_off_a: assert property (!power_on_sense |=>
    !(master_pll_rst_n | cpu_rst_n | mirror_park)) else $error("out on");
  pll_go_a: assert property ($rose(power_on_sense) |=> master_pll_rst_n) else $error("pll");
  hold_len_a: assert property (disable iff (!reset_n || !power_on_sense)
    $rose(master_pll_rst_n) |-> s_hold) else $error("hold");
  cpu_clk_a: assert property ($rose(cpu_rst_n) |-> cpu_clk_en) else $error("clk");
  periph_off_a: assert property (!cpu_rst_n |-> periph_clk_en == 0) else $error("off");
  periph_follow_a: assert property (power_on_sense && cpu_rst_n && $past(cpu_rst_n) &&
    !sys_reset_req |=> periph_clk_en == $past(periph_release)) else $error("follow");
  sys_rst_a: assert property (sys_reset_req |=> !cpu_rst_n && periph_rst_n == 0)
    else $error("sys");
  mirror_park_a: assert property (!supply_fail_warning_n && cpu_rst_n && power_on_sense
    |=> mirror_park) else $error("park");
endmodule
bind pors_sequencer pors_seq_monitor #(.HOLD_CYCLES(HOLD_CYCLES)) u_mon (.*);

// ### test/pors_supervisor.sv
// supervisor model: drives sense and warning on rising clk edges
module pors_supervisor #(parameter int LEAD = 50000) (input wire clk, // clock
  output logic power_on_sense = 0, output logic supply_fail_warning_n = 1); // outputs
  timeunit 1ns;
  timeprecision 1ns;
  task up(int n);
    repeat (n) @(posedge clk);
    {power_on_sense, supply_fail_warning_n} <= 2'b11;
  endtask
  task warn; @(posedge clk) supply_fail_warning_n <= 0; endtask
  task drop;
    repeat (LEAD) @(posedge clk);
    power_on_sense <= 0;
  endtask
endmodule

// ### test/testbench.sv
// bench: supervisor model powers the sequencer; hold cut to 20 cycles
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset_n = 0, sys_reset_req = 0, low_power_req = 0;
  logic [7:0] periph_release = 8'ha5;
  wire power_on_sense, supply_fail_warning_n, master_pll_rst_n, cpu_rst_n, cpu_clk_en;
  wire mirror_park, low_power_mode;
  wire [7:0] periph_clk_en, periph_rst_n;
  int failures = 0, tests_run = 0, t;
`define CK(w, e, s) begin tests_run++; if ((s) !== (e)) begin failures++; \
  $display("MISMATCH %s exp %0h got %0h", w, e, s); end end
  pors_sequencer #(.HOLD_CYCLES(20)) u_pors_sequencer (.*);
  pors_supervisor #(.LEAD(30)) sup (.*);
  initial forever #5 clk = ~clk;
  task cyc(int k); repeat (k) @(negedge clk); endtask
  task t_boot;
    repeat (10) @(posedge clk);
    reset_n <= 1;
    cyc(2);
    `CK("off", 3'b000, {master_pll_rst_n, cpu_rst_n, mirror_park})
    sup.up(4);
    @(posedge master_pll_rst_n) t = $time;
    @(posedge cpu_rst_n) `CK("hold", 200, $time - t)
    cyc(2);
    `CK("run", 17'h1_a5a5, {cpu_clk_en, periph_clk_en, periph_rst_n})
    @(posedge clk) low_power_req <= 1;
    cyc(2);
    `CK("low power", 1'b1, low_power_mode)
    $display("boot done");
  endtask
  task t_down;
    @(posedge clk) sys_reset_req <= 1;
    cyc(2);
    `CK("sys", 2'b10, {master_pll_rst_n, cpu_rst_n})
    @(posedge clk) sys_reset_req <= 0;
    sup.warn;
    cyc(4);
    `CK("back park", 2'b11, {cpu_rst_n, mirror_park})
    sup.drop;
    cyc(2);
    `CK("down", 4'h0, {master_pll_rst_n, cpu_rst_n, mirror_park, low_power_mode})
    sup.up(2);
    cyc(2);
    `CK("again", 1'b1, master_pll_rst_n)
    $display("down done");
  endtask
  task end_sim;
    $display("checks %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin t_boot; t_down; end_sim; end
  initial begin #4000; failures++; end_sim; end
endmodule
